// ---- iopm_defs.svh ----
// Contract
// - Array, data, address-in, peripheral, reset modes fixed
// - Control bit zero selects host I/O mode
// - Host I/O: data-out drives, data-in reads
// - Ports A, B, C default host I/O
// - Direction bit or enable term sets direction
// - Ports A, B, C, F: enable ORs direction and term
// - Array output tri-stated without term and direction
// - E, F, G address out: enable, or direction and control
// - Address nibbles a3-a0, a7-a4, a15-a8 per port; code drives full a7-a0 on E and F, a15-a8 on G
// - Non-multiplexed host: F, G become data bus
// - Peripheral mode needs enable bit and select terms
// - Test port shares port E, three enables
// - Reset pattern drives fixed level on F, G
// - Enable is mapping bit 7; buffer off without selects
// - Pattern only in reset without bus cycle
`ifndef IOPM_DEFS_SVH
`define IOPM_DEFS_SVH
`define IOPM_NPORT 7
`define IOPM_PA 0
`define IOPM_PB 1
`define IOPM_PC 2
`define IOPM_PD 3
`define IOPM_PE 4
`define IOPM_PF 5
`define IOPM_PG 6
`define IOPM_RST_VAL 8'h00
`define IOPM_PIO_BIT 7
`define IOPM_SEL_NONE 3'h0
`define IOPM_SEL_DOUT 3'h1
`define IOPM_SEL_ARRAY 3'h2
`define IOPM_SEL_ADDR 3'h3
`define IOPM_SEL_DATA 3'h4
`define IOPM_SEL_PERI 3'h5
`define IOPM_SEL_PAT 3'h6
`define IOPM_SEL_TEST 3'h7
`endif

// ---- iopm_pkg.sv ----
package iopm_pkg;
	typedef logic [7:0] iopm_byte_t;
	typedef iopm_byte_t [6:0] iopm_ports_t;
	typedef struct packed {
		iopm_ports_t array_en;
		iopm_ports_t array_in;
		logic        nonmux_bus;
		logic        reset_mode;
		iopm_byte_t  pat_f;
		iopm_byte_t  pat_g;
		logic        test_en_a;
		logic        test_en_b;
		logic        test_en_c;
		iopm_byte_t  test_mask;
	} iopm_cfg_t;
	typedef struct packed {
		logic       wr;
		logic [2:0] port;
		logic [1:0] reg_sel;
		iopm_byte_t wdata;
	} iopm_wr_t;
	typedef enum logic [1:0] {
		IOPM_REG_DOUT = 2'b00,
		IOPM_REG_DIR  = 2'b01,
		IOPM_REG_CTL  = 2'b10
	} iopm_reg_t;
	typedef enum logic [1:0] {
		IOPM_ST_RUN     = 2'b00,
		IOPM_ST_PATTERN = 2'b01,
		IOPM_ST_HOLD    = 2'b10
	} iopm_state_t;
endpackage

// ---- iopm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module iopm_sync
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] din,
	output var  logic [7:0] dout
);
	logic [7:0] s1_q;
	logic [7:0] s1_d;
	logic [7:0] s2_d;

	always_comb
	begin
		s1_d = din;
		s2_d = s1_q;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s1_q <= 8'h00;
			dout <= 8'h00;
		end
		else
		begin
			s1_q <= s1_d;
			dout <= s2_d;
		end
	end
endmodule
`default_nettype wire

// ---- iopm_pin.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iopm_defs.svh"
module iopm_pin
(
	input  wire logic       has_ctl,
	input  wire logic       oe_or_dir,
	input  wire logic       array_en,
	input  wire logic       array_in,
	input  wire logic       array_oe,
	input  wire logic       dir,
	input  wire logic       ctl,
	input  wire logic       fixed_en,
	input  wire logic [2:0] fixed_sel,
	output var  logic [2:0] sel,
	output var  logic       oe
);
	logic drive_en;

	always_comb
	begin
		drive_en = oe_or_dir ? (dir | array_oe) : dir;
		sel = `IOPM_SEL_NONE;
		oe = 1'b0;
		if (fixed_en)
		begin
			sel = fixed_sel;
			oe = fixed_sel != `IOPM_SEL_NONE;
		end
		else if (array_en)
		begin
			sel = `IOPM_SEL_ARRAY;
			oe = !array_in && (array_oe || dir);
		end
		else if (has_ctl && (array_oe || (dir && ctl)))
		begin
			sel = `IOPM_SEL_ADDR;
			oe = 1'b1;
		end
		else
		begin
			sel = `IOPM_SEL_DOUT;
			oe = drive_en;
		end
	end
endmodule
`default_nettype wire

// ---- iopm_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iopm_defs.svh"
module iopm_top
(
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire iopm_pkg::iopm_cfg_t  cfg,
	input  wire iopm_pkg::iopm_wr_t   host_wr,
	input  wire logic [2:0]           rd_port,
	input  wire iopm_pkg::iopm_ports_t array_out,
	input  wire iopm_pkg::iopm_ports_t array_oe,
	input  wire logic [15:0]          host_addr,
	input  wire logic                 addr_latch,
	input  wire logic [15:0]          host_wdata,
	input  wire logic                 host_data_oe,
	input  wire logic                 bus_cycle,
	input  wire logic                 dev_reset,
	input  wire logic                 periph_select_zero,
	input  wire logic                 periph_select_one,
	input  wire logic [7:0]           memory_mapping_reg,
	input  wire logic [7:0]           test_out,
	input  wire logic [7:0]           test_oe,
	input  wire iopm_pkg::iopm_ports_t pin_in,
	output var  iopm_pkg::iopm_ports_t pin_out,
	output var  iopm_pkg::iopm_ports_t pin_oe,
	output var  logic [7:0]           rd_data,
	output var  iopm_pkg::iopm_ports_t pin_sync,
	output var  logic [1:0]           state
);
	import iopm_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	iopm_ports_t dout_q;
	iopm_ports_t dout_d;
	iopm_ports_t dir_q;
	iopm_ports_t dir_d;
	iopm_ports_t ctl_q;
	iopm_ports_t ctl_d;
	iopm_byte_t  alat_lo_q;
	iopm_byte_t  alat_lo_d;
	iopm_byte_t  alat_hi_q;
	iopm_byte_t  alat_hi_d;
	iopm_state_t st_q;
	iopm_state_t st_d;
	iopm_ports_t out_d;
	iopm_ports_t oe_d;
	iopm_byte_t  rd_d;
	iopm_ports_t pin_s;
	logic [2:0]  fsel [7][8];
	logic        fen [7][8];
	logic        test_on;
	logic        peri_on;
	logic        peri_act;
	iopm_byte_t  aval [7];

	genvar gp;
	genvar gb;
	generate
		for (gp = 0; gp < `IOPM_NPORT; gp++)
		begin : g_sync
			iopm_sync u_sync
			(
				.mclk  (mclk),
				.rst_n (rst_n),
				.din   (pin_in[gp]),
				.dout  (pin_s[gp])
			);
		end
	endgenerate

	// ****************************************
	// Host register writes
	// ****************************************
	always_comb
	begin
		dout_d = dout_q;
		dir_d = dir_q;
		ctl_d = ctl_q;
		if (host_wr.wr && host_wr.port < 3'(`IOPM_NPORT))
		begin
			unique case (host_wr.reg_sel)
				IOPM_REG_DOUT: dout_d[host_wr.port] = host_wr.wdata;
				IOPM_REG_DIR:  dir_d[host_wr.port] = host_wr.wdata;
				IOPM_REG_CTL:
				begin
					if (host_wr.port >= 3'(`IOPM_PE))
						ctl_d[host_wr.port] = host_wr.wdata;
				end
				default: dout_d = dout_q;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			dout_q <= '0;
			dir_q <= '0;
			ctl_q <= '0;
		end
		else
		begin
			dout_q <= dout_d;
			dir_q <= dir_d;
			ctl_q <= ctl_d;
		end
	end

	// ****************************************
	// Address latch
	// ****************************************
	always_comb
	begin
		alat_lo_d = addr_latch ? host_addr[7:0] : alat_lo_q;
		alat_hi_d = addr_latch ? host_addr[15:8] : alat_hi_q;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			alat_lo_q <= `IOPM_RST_VAL;
			alat_hi_q <= `IOPM_RST_VAL;
		end
		else
		begin
			alat_lo_q <= alat_lo_d;
			alat_hi_q <= alat_hi_d;
		end
	end

	// ****************************************
	// Reset pattern sequencer
	// ****************************************
	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			IOPM_ST_RUN:
				if (cfg.reset_mode && dev_reset && !bus_cycle)
					st_d = IOPM_ST_PATTERN;
			IOPM_ST_PATTERN:
				if (!dev_reset)
					st_d = IOPM_ST_RUN;
				else if (bus_cycle)
					st_d = IOPM_ST_HOLD;
			IOPM_ST_HOLD:
				if (!dev_reset)
					st_d = IOPM_ST_RUN;
				else if (!bus_cycle)
					st_d = IOPM_ST_PATTERN;
			default: st_d = IOPM_ST_RUN;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			st_q <= IOPM_ST_RUN;
		else
			st_q <= st_d;
	end

	// ****************************************
	// Per-pin mode selection
	// ****************************************
	always_comb
	begin
		test_on = cfg.test_en_a | cfg.test_en_b | cfg.test_en_c;
		peri_on = memory_mapping_reg[`IOPM_PIO_BIT];
		peri_act = peri_on && (periph_select_zero || periph_select_one);
		aval[`IOPM_PA] = 8'h00;
		aval[`IOPM_PB] = 8'h00;
		aval[`IOPM_PC] = 8'h00;
		aval[`IOPM_PD] = 8'h00;
		aval[`IOPM_PE] = alat_lo_q;
		aval[`IOPM_PF] = alat_lo_q;
		aval[`IOPM_PG] = alat_hi_q;
	end

	// ****************************************
	// Fixed-function pin claims
	// ****************************************
	always_comb
	begin
		for (int p = 0; p < `IOPM_NPORT; p++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				fen[p][b] = 1'b0;
				fsel[p][b] = `IOPM_SEL_NONE;
				if (p == `IOPM_PE && test_on && cfg.test_mask[b])
				begin
					fen[p][b] = 1'b1;
					fsel[p][b] = test_oe[b] ? `IOPM_SEL_TEST
						: `IOPM_SEL_NONE;
				end
				else if ((p == `IOPM_PF || p == `IOPM_PG)
					&& st_q == IOPM_ST_PATTERN)
				begin
					fen[p][b] = 1'b1;
					fsel[p][b] = `IOPM_SEL_PAT;
				end
				else if ((p == `IOPM_PF || p == `IOPM_PG)
					&& cfg.nonmux_bus)
				begin
					fen[p][b] = 1'b1;
					fsel[p][b] = host_data_oe ? `IOPM_SEL_DATA
						: `IOPM_SEL_NONE;
				end
				else if (p == `IOPM_PF && peri_on)
				begin
					fen[p][b] = 1'b1;
					fsel[p][b] = (peri_act && host_data_oe)
						? `IOPM_SEL_PERI : `IOPM_SEL_NONE;
				end
			end
		end
	end

	generate
		for (gp = 0; gp < `IOPM_NPORT; gp++)
		begin : g_port
			for (gb = 0; gb < 8; gb++)
			begin : g_bit
				logic [2:0] s;
				logic       o;
				iopm_pin u_pin
				(
					.has_ctl   (gp >= `IOPM_PE),
					.oe_or_dir (gp <= `IOPM_PC || gp == `IOPM_PF),
					.array_en  (cfg.array_en[gp][gb]),
					.array_in  (cfg.array_in[gp][gb]),
					.array_oe  (array_oe[gp][gb]),
					.dir       (dir_q[gp][gb]),
					.ctl       (ctl_q[gp][gb]),
					.fixed_en  (fen[gp][gb]),
					.fixed_sel (fsel[gp][gb]),
					.sel       (s),
					.oe        (o)
				);
				always_comb
				begin
					unique case (s)
						`IOPM_SEL_DOUT:  out_d[gp][gb] = dout_q[gp][gb];
						`IOPM_SEL_ARRAY: out_d[gp][gb] = array_out[gp][gb];
						`IOPM_SEL_ADDR:  out_d[gp][gb] = aval[gp][gb];
						`IOPM_SEL_DATA:  out_d[gp][gb] =
							(gp == `IOPM_PG) ? host_wdata[8+gb] : host_wdata[gb];
						`IOPM_SEL_PERI:  out_d[gp][gb] = host_wdata[gb];
						`IOPM_SEL_PAT:   out_d[gp][gb] =
							(gp == `IOPM_PG) ? cfg.pat_g[gb] : cfg.pat_f[gb];
						`IOPM_SEL_TEST:  out_d[gp][gb] = test_out[gb];
						default:         out_d[gp][gb] = 1'b0;
					endcase
					oe_d[gp][gb] = o;
				end
			end
		end
	endgenerate

	// ****************************************
	// Host read path
	// ****************************************
	always_comb
	begin
		rd_d = 8'h00;
		if (rd_port < 3'(`IOPM_NPORT))
			rd_d = pin_s[rd_port];
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rd_data <= 8'h00;
			pin_sync <= '0;
		end
		else
		begin
			rd_data <= rd_d;
			pin_sync <= pin_s;
		end
	end

	// ****************************************
	// Pin drive and state outputs
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pin_out <= '0;
			pin_oe <= '0;
			state <= 2'b00;
		end
		else
		begin
			pin_out <= out_d;
			pin_oe <= oe_d;
			state <= st_d;
		end
	end
endmodule
`default_nettype wire

// ---- iopm_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module iopm_chk
(
	input wire logic                  mclk,
	input wire logic                  rst_n,
	input wire iopm_pkg::iopm_cfg_t   cfg,
	input wire logic [15:0]           host_wdata,
	input wire logic                  host_data_oe,
	input wire logic                  bus_cycle,
	input wire logic                  dev_reset,
	input wire logic [2:0]            rd_port,
	input wire iopm_pkg::iopm_ports_t pin_in,
	input wire iopm_pkg::iopm_ports_t pin_out,
	input wire iopm_pkg::iopm_ports_t pin_oe,
	input wire logic [7:0]            rd_data,
	input wire iopm_pkg::iopm_ports_t pin_sync,
	input wire logic [1:0]            state
);
	import iopm_pkg::*;
	// *****
	// Pin mode checks
	// *****
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence in_pat;
		(state == IOPM_ST_PATTERN) [*2];
	endsequence
	sequence bus_steady;
		(cfg.nonmux_bus && host_data_oe && state == IOPM_ST_RUN
			&& $stable(host_wdata)) [*3];
	endsequence
	reset_clear_a: assert property (disable iff (1'b0)
		!rst_n |=> pin_oe == '0 && state == IOPM_ST_RUN)
		else $error("outputs not cleared by reset");
	pat_entry_a: assert property (
		$rose(state == IOPM_ST_PATTERN)
		|-> $past(dev_reset && !bus_cycle && cfg.reset_mode))
		else $error("pattern entered without cause");
	pat_drive_a: assert property (in_pat |->
		pin_out[5] == cfg.pat_f && pin_out[6] == cfg.pat_g
		&& pin_oe[5] == 8'hFF && pin_oe[6] == 8'hFF)
		else $error("pattern not driven");
	pat_hold_a: assert property (
		state == IOPM_ST_PATTERN && bus_cycle && dev_reset
		|=> state == IOPM_ST_HOLD)
		else $error("pattern not paused by bus cycle");
	array_off_a: assert property (
		cfg.array_in != '0 |-> (pin_oe & cfg.array_in) == '0)
		else $error("array input pin driven");
	data_port_a: assert property (bus_steady |->
		pin_oe[5] == 8'hFF && pin_oe[6] == 8'hFF
		&& {pin_out[6], pin_out[5]} == host_wdata)
		else $error("data port not driven");
	pin_sync_a: assert property (
		$past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3)
		|-> pin_sync == $past(pin_in, 3))
		else $error("pin sync latency wrong");
	read_data_a: assert property (
		$stable(rd_port) && rd_port < 3'h7 && $past(rst_n)
		|-> rd_data == pin_sync[rd_port])
		else $error("read data wrong");
endmodule
`default_nettype wire

// ---- iopm_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module iopm_host
(
	input  wire logic                mclk,
	input  wire iopm_pkg::iopm_cfg_t cfg,
	output var  iopm_pkg::iopm_wr_t  host_wr
);
	import iopm_pkg::*;
	// *****
	// Host register writes
	// *****
	initial host_wr = '0;
	task automatic put(input logic [2:0] p, input iopm_reg_t r,
		input iopm_byte_t d);
		iopm_byte_t m;
		m = d;
		if (r == IOPM_REG_DIR)
			m = d & ~cfg.array_in[p];
		@(posedge mclk);
		host_wr <= '{1'b1, p, r, m};
	endtask
	task automatic idle();
		@(posedge mclk);
		host_wr.wr <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb_iopm_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	error_cnt++; $display("mismatch %0t got %h exp %h", $time, a, b); \
	end end
module tb_iopm_top;
	import iopm_pkg::*;
	logic        mclk, rst_n, addr_latch, host_data_oe, bus_cycle;
	logic        dev_reset, periph_select_zero, periph_select_one;
	iopm_cfg_t   cfg;
	iopm_wr_t    host_wr;
	logic [2:0]  rd_port;
	iopm_ports_t array_out, array_oe, pin_in, pin_out, pin_oe, pin_sync;
	logic [15:0] host_addr, host_wdata;
	logic [7:0]  memory_mapping_reg, test_out, test_oe, rd_data;
	logic [1:0]  state;
	int          error_cnt, samples_checked;
	// *****
	// Harness
	// *****
	iopm_host host_u (.mclk, .cfg, .host_wr);
	iopm_top dut_u (.mclk, .rst_n, .cfg, .host_wr, .rd_port, .array_out,
		.array_oe, .host_addr, .addr_latch, .host_wdata, .host_data_oe,
		.bus_cycle, .dev_reset, .periph_select_zero, .periph_select_one,
		.memory_mapping_reg, .test_out, .test_oe, .pin_in, .pin_out,
		.pin_oe, .rd_data, .pin_sync, .state);
	always #25 mclk = ~mclk;
	task automatic look(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic do_reset();
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// *****
	// Scenarios
	// *****
	task automatic t_dout();
		`CHK(pin_oe, 56'h0)
		for (int p = 0; p < 7; p++)
		begin
			host_u.put(p[2:0], IOPM_REG_DOUT, 8'h5A ^ p[7:0]);
			host_u.put(p[2:0], IOPM_REG_DIR, 8'h0F);
		end
		host_u.idle();
		look(2);
		for (int p = 0; p < 7; p++)
		begin
			`CHK(pin_oe[p], 8'h0F)
			`CHK(pin_out[p] & 8'h0F, (8'h5A ^ p[7:0]) & 8'h0F)
		end
	endtask
	task automatic t_oe();
		@(posedge mclk);
		array_oe[0] <= 8'hF0;
		array_oe[3] <= 8'hF0;
		memory_mapping_reg <= 8'h80;
		look(3);
		`CHK(pin_oe[0], 8'hFF)
		`CHK(pin_out[0], 8'h5A)
		`CHK(pin_oe[3], 8'h0F)
		`CHK(pin_oe[5], 8'h00)
		@(posedge mclk);
		periph_select_zero <= 1'b1;
		host_data_oe <= 1'b1;
		host_wdata <= 16'h00C3;
		look(2);
		`CHK(pin_oe[5], 8'hFF)
		`CHK(pin_out[5], 8'hC3)
		@(posedge mclk);
		periph_select_zero <= 1'b0;
		host_data_oe <= 1'b0;
	endtask
	task automatic t_addr();
		@(posedge mclk);
		host_addr <= 16'hA53C;
		addr_latch <= 1'b1;
		@(posedge mclk);
		addr_latch <= 1'b0;
		@(posedge mclk);
		host_addr <= 16'h0000;
		host_u.put(3'd6, IOPM_REG_CTL, 8'hFF);
		host_u.put(3'd6, IOPM_REG_DIR, 8'hFF);
		host_u.put(3'd4, IOPM_REG_CTL, 8'hFF);
		host_u.put(3'd0, IOPM_REG_CTL, 8'hFF);
		host_u.idle();
		look(2);
		`CHK(pin_oe[6], 8'hFF)
		`CHK(pin_out[6], 8'hA5)
		`CHK(pin_out[4] & 8'h0F, 8'h0C)
		`CHK(pin_out[0], 8'h5A)
	endtask
	task automatic t_read();
		@(posedge mclk);
		pin_in[2] <= 8'hC3;
		rd_port <= 3'd2;
		look(4);
		`CHK(rd_data, 8'hC3)
	endtask
	task automatic t_pat();
		look(3);
		`CHK(state, IOPM_ST_PATTERN)
		`CHK({pin_out[6], pin_out[5]}, 16'h6996)
		@(posedge mclk);
		bus_cycle <= 1'b1;
		look(2);
		`CHK(state, IOPM_ST_HOLD)
		`CHK(pin_oe[5], 8'h00)
		@(posedge mclk);
		bus_cycle <= 1'b0;
		dev_reset <= 1'b0;
		host_data_oe <= 1'b1;
		host_wdata <= 16'h1234;
		look(4);
		`CHK(state, IOPM_ST_RUN)
		`CHK({pin_out[6], pin_out[5]}, 16'h1234)
		@(posedge mclk);
		host_data_oe <= 1'b0;
		host_u.put(3'd5, IOPM_REG_DIR, 8'hFF);
		host_u.idle();
		look(2);
		`CHK(pin_oe[5], 8'h00)
	endtask
	task automatic t_array();
		@(posedge mclk);
		array_oe[1] <= 8'hF0;
		array_out[1] <= 8'hA0;
		host_u.put(3'd1, IOPM_REG_DOUT, 8'hFF);
		host_u.put(3'd1, IOPM_REG_DIR, 8'hFF);
		host_u.idle();
		look(2);
		`CHK(pin_oe[1], 8'hF0)
		`CHK(pin_out[1] & 8'hF0, 8'hA0)
		@(posedge mclk);
		array_oe[1] <= 8'h00;
		host_u.put(3'd1, IOPM_REG_DIR, 8'h00);
		host_u.idle();
		look(2);
		`CHK(pin_oe[1], 8'h00)
	endtask
	initial
	begin
		{mclk, addr_latch, host_data_oe, bus_cycle, dev_reset} = '0;
		{periph_select_zero, periph_select_one, rd_port} = '0;
		{cfg, array_out, array_oe, pin_in, host_addr, host_wdata} = '0;
		{memory_mapping_reg, test_out, test_oe} = '0;
		rst_n = 1'b0;
		do_reset();
		look(1);
		t_dout();
		t_oe();
		t_addr();
		t_read();
		@(posedge mclk);
		rst_n <= 1'b0;
		cfg.array_en[1] <= 8'hFF;
		cfg.array_in[1] <= 8'h0F;
		cfg.nonmux_bus <= 1'b1;
		cfg.reset_mode <= 1'b1;
		cfg.pat_f <= 8'h96;
		cfg.pat_g <= 8'h69;
		dev_reset <= 1'b1;
		do_reset();
		t_pat();
		t_array();
		stop_test();
	end
	initial
	begin
		#100000;
		error_cnt++;
		stop_test();
	end
endmodule
bind iopm_top iopm_chk chk_u (.mclk, .rst_n, .cfg, .host_wdata,
	.host_data_oe, .bus_cycle, .dev_reset, .rd_port, .pin_in, .pin_out,
	.pin_oe, .rd_data, .pin_sync, .state);
`default_nettype wire
